// >>> core/qdf_pkg.sv
// Purpose: constants, field layout and types of the quadrature decoder
// Assumes: 16-bit register port with 4-bit word address
// Notes: reserved bits read as zero
// Operation
// [RULE_01] source-select bit picks timer direction source
// [RULE_02] filter passes level after three equal samples
// [RULE_03] filter clock is divided instruction clock
// [RULE_04] phase divider codes give 1:1 to 1:256
// [RULE_05] index divider uses same eight ratios
// [RULE_06] phase filter enable routes phases through filter
// [RULE_07] index filter enable routes index through filter
// [RULE_08] all filters disabled after reset
// [RULE_09] alternate layout: phase settings govern index filter
// [RULE_10] index match bits qualify accepted index pulses
// [RULE_11] mode msb set selects position measurement
// [RULE_12] mode middle bit selects x4 counting
// [RULE_13] mode 10x counts phase A edges only
// [RULE_14] A edge against last B edge sets direction
// [RULE_15] B edge against last A edge sets direction
// [RULE_16] same-channel repeat edge toggles direction
// [RULE_17] direction drives pin and status bit
// [RULE_18] swap clear feeds pins straight through
// [RULE_19] swap set exchanges the two phases
// [RULE_20] direction bit writable only in timer mode
// [RULE_21] error disable bit masks count-error request
// [RULE_22] filter is divider plus sample shift register
package qdf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register word addresses
  localparam logic [3:0] OFS_DEC_CTRL = 4'h0;
  localparam logic [3:0] OFS_FILT_CTRL = 4'h1;
  localparam logic [3:0] OFS_POS_COUNT = 4'h2;

  // decoder control fields
  localparam int DEC_ERR_BIT = 15;
  localparam int DEC_INDEX_BIT = 12;
  localparam int DEC_DIR_BIT = 11;
  localparam int DEC_MODE_LSB = 8;
  localparam int DEC_SWAP_BIT = 7;
  localparam int DEC_PINEN_BIT = 6;
  localparam int DEC_SRC_BIT = 0;
  localparam logic [15:0] DEC_WR_MASK = 16'h07c1;
  localparam logic [15:0] DEC_CTRL_RST = 16'h0000;

  // filter control fields
  localparam int FLT_IMV_LSB = 9;
  localparam int FLT_COUNT_ERROR_IRQ_DISABLE_BIT = 8;
  localparam int FLT_PHEN_BIT = 7;
  localparam int FLT_PHDIV_LSB = 4;
  localparam int FLT_IDEN_BIT = 3;
  localparam int FLT_IDDIV_LSB = 0;
  localparam logic [15:0] FLT_MASK_STD = 16'h01ff;
  localparam logic [15:0] FLT_MASK_ALT = 16'h07f0;
  localparam logic [15:0] FLT_CTRL_RST = 16'h0000;
  localparam logic [15:0] POS_COUNT_RST = 16'h0000;

  localparam logic [2:0] MODE_TIMER_SW = 3'h1;

  typedef struct packed {
    logic index;
    logic phase_b;
    logic phase_a;
  } qdf_pins_t;

  typedef enum logic {
    LAST_A = 1'b0,
    LAST_B = 1'b1
  } qdf_last_t;

  // divider terminal count (ratio minus one) per code
  function automatic logic [7:0] div_terminal(input logic [2:0] code);
    logic [7:0] t;
    t = 8'h00;
    unique case (code)
      3'h0: t = 8'h00;
      3'h1: t = 8'h01;
      3'h2: t = 8'h03;
      3'h3: t = 8'h0f;
      3'h4: t = 8'h1f;
      3'h5: t = 8'h3f;
      3'h6: t = 8'h7f;
      3'h7: t = 8'hff;
    endcase
    return t;
  endfunction : div_terminal
endpackage : qdf_pkg

// >>> core/qdf_decoder.sv
// Purpose: quadrature decoder front end with input noise filters
// Assumes: clk_i is the instruction clock; pins are asynchronous
// Notes: ALT_LAYOUT selects the filter register layout with match bits
`timescale 1ns/100ps
module qdf_decoder #(
  parameter bit ALT_LAYOUT = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire qdf_pkg::qdf_pins_t pins_i,
  input wire logic pin_direction_ctrl_i,
  input wire logic [qdf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [qdf_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [qdf_pkg::DATA_W-1:0] rdata_o,
  output logic count_up_o,
  output logic count_dn_o,
  output logic direction_o,
  output logic dir_pin_o,
  output logic dir_pin_oe_n_o,
  output logic index_accept_o,
  output logic count_error_irq_o
);
  import qdf_pkg::*;

  qdf_pins_t sync1_reg, sync2_reg;
  logic [15:0] dec_ctrl_reg, filt_ctrl_reg, pos_count_reg;
  logic [15:0] rdata_reg;
  logic [7:0] ph_cnt_reg, id_cnt_reg;
  logic [2:0] samp_reg [3];
  logic [2:0] filt_reg;
  logic [2:0] chan;
  logic prev_a_reg, prev_b_reg, primed_reg;
  qdf_last_t last_ch_reg;
  logic last_rise_reg;
  logic dir_flag_reg, dir_flag_next;
  logic err_reg;
  logic up_reg, dn_reg;
  logic ph_tick, id_tick;
  logic [7:0] ph_term, id_term;
  logic [2:0] mode;
  logic pos_mode, x4_mode;
  logic ph_en, id_en;
  logic [2:0] ph_div, id_div;
  logic [1:0] imv;
  logic dec_a, dec_b;
  logic a_edge, b_edge;
  logic up_next, dn_next, err_set, dir_upd;
  logic dir_eff, idx_match;

  // input synchroniser
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign mode = dec_ctrl_reg[DEC_MODE_LSB +: 3];
  // [RULE_11] position modes
  assign pos_mode = mode[2];
  // [RULE_12] x4 select
  assign x4_mode = mode[1];
  assign ph_en = filt_ctrl_reg[FLT_PHEN_BIT];
  assign ph_div = filt_ctrl_reg[FLT_PHDIV_LSB +: 3];
  assign imv = filt_ctrl_reg[FLT_IMV_LSB +: 2];
  // [RULE_09] shared index settings
  assign id_en = ALT_LAYOUT ? ph_en : filt_ctrl_reg[FLT_IDEN_BIT];
  assign id_div = ALT_LAYOUT ? ph_div : filt_ctrl_reg[FLT_IDDIV_LSB +: 3];

  // [RULE_04] phase divide ratio
  assign ph_term = div_terminal(ph_div);
  // [RULE_05] index divide ratio
  assign id_term = div_terminal(id_div);
  assign ph_tick = (ph_cnt_reg >= ph_term);
  assign id_tick = (id_cnt_reg >= id_term);

  // [RULE_03] filter clock dividers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_cnt_reg <= 8'h00;
      id_cnt_reg <= 8'h00;
    end else begin
      ph_cnt_reg <= ph_tick ? 8'h00 : ph_cnt_reg + 8'h01;
      id_cnt_reg <= id_tick ? 8'h00 : id_cnt_reg + 8'h01;
    end
  end

  // [RULE_22] sample shift register per channel
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 3; i++) begin
        samp_reg[i] <= 3'h0;
      end
      filt_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == 2) ? id_tick : ph_tick) begin
          samp_reg[i] <= {samp_reg[i][1:0], sync2_reg[i]};
          // [RULE_02] three equal samples
          if (samp_reg[i][1:0] == {2{sync2_reg[i]}}) begin
            filt_reg[i] <= sync2_reg[i];
          end
        end
      end
    end
  end

  // [RULE_06] phase filter bypass
  assign chan[0] = ph_en ? filt_reg[0] : sync2_reg.phase_a;
  assign chan[1] = ph_en ? filt_reg[1] : sync2_reg.phase_b;
  // [RULE_07] index filter bypass
  assign chan[2] = id_en ? filt_reg[2] : sync2_reg.index;

  // [RULE_18] straight feed when clear
  // [RULE_19] exchange when swap set
  assign dec_a = dec_ctrl_reg[DEC_SWAP_BIT] ? chan[1] : chan[0];
  assign dec_b = dec_ctrl_reg[DEC_SWAP_BIT] ? chan[0] : chan[1];
  assign a_edge = primed_reg & (dec_a ^ prev_a_reg);
  assign b_edge = primed_reg & (dec_b ^ prev_b_reg);

  // lead/lag test
  always_comb begin
    up_next = 1'b0;
    dn_next = 1'b0;
    err_set = 1'b0;
    dir_upd = 1'b0;
    dir_flag_next = dir_flag_reg;
    if (pos_mode) begin
      if (a_edge && b_edge) begin
        // both phases moved at once: step lost
        err_set = 1'b1;
      end else if (a_edge || b_edge) begin
        dir_upd = 1'b1;
        if (a_edge && last_ch_reg == LAST_B) begin
          // [RULE_14] A against prior B
          dir_flag_next = dec_a ^ last_rise_reg;
        end else if (b_edge && last_ch_reg == LAST_A) begin
          // [RULE_15] B against prior A
          dir_flag_next = ~(dec_b ^ last_rise_reg);
        end else begin
          // [RULE_16] same-channel reversal
          dir_flag_next = ~dir_flag_reg;
        end
        // [RULE_13] x2 ignores B edges for counting
        if (a_edge || x4_mode) begin
          up_next = dir_flag_next;
          dn_next = ~dir_flag_next;
        end
      end
    end
  end

  // edge history
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
      primed_reg <= 1'b0;
      last_ch_reg <= LAST_A;
      last_rise_reg <= 1'b0;
    end else begin
      prev_a_reg <= dec_a;
      prev_b_reg <= dec_b;
      primed_reg <= 1'b1;
      if (dir_upd) begin
        last_ch_reg <= a_edge ? LAST_A : LAST_B;
        last_rise_reg <= a_edge ? dec_a : dec_b;
      end
    end
  end

  // direction flag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_flag_reg <= 1'b0;
    end else if (dir_upd) begin
      dir_flag_reg <= dir_flag_next;
    end else if (wr_i && addr_i == OFS_DEC_CTRL && mode == MODE_TIMER_SW) begin
      // [RULE_20] software direction in timer mode
      dir_flag_reg <= wdata_i[DEC_DIR_BIT];
    end
  end

  // [RULE_01] timer direction source
  assign dir_eff = (!pos_mode && dec_ctrl_reg[DEC_SRC_BIT]) ?
                   sync2_reg.phase_b : dir_flag_reg;

  // count pulses and position count
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      pos_count_reg <= POS_COUNT_RST;
    end else begin
      up_reg <= up_next;
      dn_reg <= dn_next;
      if (wr_i && addr_i == OFS_POS_COUNT) begin
        pos_count_reg <= wdata_i;
      end else if (up_next) begin
        pos_count_reg <= pos_count_reg + 16'h0001;
      end else if (dn_next) begin
        pos_count_reg <= pos_count_reg - 16'h0001;
      end
    end
  end

  // count error flag: a new error wins over a software clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_reg <= 1'b0;
    end else if (err_set) begin
      err_reg <= 1'b1;
    end else if (wr_i && addr_i == OFS_DEC_CTRL) begin
      err_reg <= err_reg & wdata_i[DEC_ERR_BIT];
    end
  end

  // control registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_ctrl_reg <= DEC_CTRL_RST;
      // [RULE_08] filters off at reset
      filt_ctrl_reg <= FLT_CTRL_RST;
    end else if (wr_i) begin
      if (addr_i == OFS_DEC_CTRL) begin
        dec_ctrl_reg <= wdata_i & DEC_WR_MASK;
      end
      if (addr_i == OFS_FILT_CTRL) begin
        filt_ctrl_reg <= wdata_i & (ALT_LAYOUT ? FLT_MASK_ALT : FLT_MASK_STD);
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_DEC_CTRL: begin
          // [RULE_17] direction status mirror
          rdata_reg <= {err_reg, 2'h0, chan[2], dir_eff,
                        dec_ctrl_reg[10:0]};
        end
        OFS_FILT_CTRL: rdata_reg <= filt_ctrl_reg;
        OFS_POS_COUNT: rdata_reg <= pos_count_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // [RULE_10] index qualification by phase state
  always_comb begin
    idx_match = 1'b1;
    if (ALT_LAYOUT) begin
      if (x4_mode) begin
        idx_match = (dec_b == imv[1]) && (dec_a == imv[0]);
      end else begin
        idx_match = ((imv[1] ? dec_b : dec_a) == imv[0]);
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign count_up_o = up_reg;
  assign count_dn_o = dn_reg;
  assign direction_o = dir_eff;
  assign index_accept_o = pos_mode & chan[2] & idx_match;
  // [RULE_17] direction pin drive
  assign dir_pin_o = dir_eff;
  assign dir_pin_oe_n_o = ~(dec_ctrl_reg[DEC_PINEN_BIT] & ~pin_direction_ctrl_i);
  // [RULE_21] error request mask
  assign count_error_irq_o = err_reg & ~filt_ctrl_reg[FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
endmodule : qdf_decoder

// >>> bench/qdf_enc_model.sv
// Purpose: encoder model driving the phase and index pins
// Assumes: one quadrature state change per step request
// Notes: jolt moves both phases at once, glitch inverts phase a
`timescale 1ns/100ps
module qdf_enc_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic rev_i,
  input wire logic jolt_i,
  input wire logic glitch_i,
  input wire logic idx_i,
  output qdf_pkg::qdf_pins_t pins_o
);
  import qdf_pkg::*;
  logic [1:0] pos_reg = 2'h0;
  logic a;
  always_ff @(posedge clk_i) begin
    if (jolt_i) begin
      pos_reg <= pos_reg + 2'h2;
    end else if (step_i) begin
      pos_reg <= rev_i ? pos_reg - 2'h1 : pos_reg + 2'h1;
    end
  end
  assign a = (pos_reg == 2'h1) || (pos_reg == 2'h2);
  assign pins_o = {idx_i, pos_reg[1], a ^ glitch_i};
endmodule : qdf_enc_model

// >>> bench/qdf_decoder_sva.sv
// Purpose: port checker for the quadrature decoder
// Assumes: copies of the control words follow bus writes
// Notes: bound to every decoder instance
`timescale 1ns/100ps
module qdf_decoder_sva
  import qdf_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire qdf_pkg::qdf_pins_t pins_i,
  input wire logic pin_direction_ctrl_i,
  input wire logic [qdf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [qdf_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [qdf_pkg::DATA_W-1:0] rdata_o,
  input wire logic count_up_o,
  input wire logic count_dn_o,
  input wire logic direction_o,
  input wire logic dir_pin_o,
  input wire logic dir_pin_oe_n_o,
  input wire logic index_accept_o,
  input wire logic count_error_irq_o
);
  logic [15:0] dec_reg;
  logic [15:0] flt_reg;
  logic cnt;
  assign cnt = count_up_o || count_dn_o;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_reg <= 16'h0000;
      flt_reg <= 16'h0000;
    end else if (wr_i && addr_i == OFS_DEC_CTRL) begin
      dec_reg <= wdata_i;
    end else if (wr_i && addr_i == OFS_FILT_CTRL) begin
      flt_reg <= wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_pins_moved;
    $past(pins_i[1:0], 2) != $past(pins_i[1:0], 6);
  endsequence
  sequence s_a_moved;
    $past(pins_i.phase_a, 2) != $past(pins_i.phase_a, 6);
  endsequence
  a_dir_pin_oe: assert property (dir_pin_oe_n_o ==
    !(dec_reg[6] && !pin_direction_ctrl_i)) else $error("pin enable");
  a_idle_no_count: assert property (!dec_reg[10] &&
    !$past(dec_reg[10], 3) |-> !cnt) else $error("count when idle");
  a_count_edge: assert property (cnt && !flt_reg[7] &&
    !$past(flt_reg[7], 6) |-> s_pins_moved) else $error("count no edge");
  a_x2_a_only: assert property (cnt && !flt_reg[7] &&
    $past(dec_reg[10:7], 6) == 4'h8 && dec_reg[10:7] == 4'h8
    |-> s_a_moved) else $error("x2 count without a edge");
  a_up_sets_dir: assert property (count_up_o && dec_reg[10]
    |-> ##[0:1] direction_o) else $error("up with dir low");
  a_dn_clears_dir: assert property (count_dn_o && dec_reg[10]
    |-> ##[0:1] !direction_o) else $error("down with dir high");
  a_pulse_single: assert property (cnt |=> !cnt)
    else $error("pulse too long");
  a_err_masked: assert property (flt_reg[8] &&
    $past(flt_reg[8]) |-> !count_error_irq_o) else $error("err unmasked");
endmodule : qdf_decoder_sva
bind qdf_decoder qdf_decoder_sva u_sva (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .pins_i(pins_i),
  .pin_direction_ctrl_i(pin_direction_ctrl_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .count_up_o(count_up_o), .count_dn_o(count_dn_o),
  .direction_o(direction_o), .dir_pin_o(dir_pin_o),
  .dir_pin_oe_n_o(dir_pin_oe_n_o), .index_accept_o(index_accept_o),
  .count_error_irq_o(count_error_irq_o));

// >>> bench/quadrature_decoder_with_filters_test.sv
// Purpose: self-checking bench for the quadrature decoder
// Assumes: standard filter layout, encoder model on the pins
// Notes: count pulses are tallied in the background
`timescale 1ns/100ps
module quadrature_decoder_with_filters_test;
  import qdf_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pdir = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic step = 1'b0;
  logic rev = 1'b0;
  logic jolt = 1'b0;
  logic glitch = 1'b0;
  logic idx = 1'b0;
  logic idx_acc;
  int n_idx = 0;
  qdf_pins_t pins;
  logic [15:0] rdata;
  logic up, dn, dir, dpin, oen, err;
  int failures = 0;
  int total_checks = 0;
  int n_up = 0;
  int n_dn = 0;
  int cycles = 0;
  int lat;
  initial forever #50 clk_i = ~clk_i;
  qdf_enc_model enc (.clk_i(clk_i), .step_i(step), .rev_i(rev),
    .jolt_i(jolt), .glitch_i(glitch), .idx_i(idx), .pins_o(pins));
  qdf_decoder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
    .pin_direction_ctrl_i(pdir), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .count_up_o(up),
    .count_dn_o(dn), .direction_o(dir), .dir_pin_o(dpin),
    .dir_pin_oe_n_o(oen), .index_accept_o(idx_acc),
    .count_error_irq_o(err));
  always @(posedge clk_i) begin
    n_idx += (idx_acc === 1'b1);
    n_up += (up === 1'b1);
    n_dn += (dn === 1'b1);
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] got,
    input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("read data", rdata, e);
  endtask : rd
  task automatic stp(input logic r, input int n);
    repeat (n) begin
      @(posedge clk_i);
      rev <= r;
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      cyc(9);
    end
  endtask : stp
  // mode word, priming steps, then four counted steps
  task automatic run(input logic [15:0] m, input logic r);
    wr(OFS_DEC_CTRL, m);
    stp(r, 2);
    n_up = 0;
    n_dn = 0;
    stp(r, 4);
  endtask : run
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_DEC_CTRL, 16'h0000);
    rd(OFS_FILT_CTRL, 16'h0000);
    rd(4'hf, 16'h0000);
    $display("reset test done");
    run(16'h0600, 1'b0);
    chk("x4 up", 16'(n_up), 16'h0004);
    chk("x4 dir", 16'(dir), 16'h0001);
    n_dn = 0;
    stp(1'b1, 4);
    chk("x4 back", 16'(n_dn), 16'h0004);
    chk("back dir", 16'(dir), 16'h0000);
    run(16'h0680, 1'b0);
    chk("swap dn", 16'(n_dn), 16'h0004);
    run(16'h0400, 1'b0);
    chk("x2 up", 16'(n_up), 16'h0002);
    $display("decode tests done");
    wr(OFS_DEC_CTRL, 16'h0600);
    wr(OFS_FILT_CTRL, 16'h00b0);
    rd(OFS_FILT_CTRL, 16'h00b0);
    cyc(60);
    n_up = 0;
    n_dn = 0;
    @(posedge clk_i);
    glitch <= 1'b1;
    @(posedge clk_i);
    glitch <= 1'b0;
    cyc(60);
    chk("glitch", 16'(n_up + n_dn), 16'h0000);
    @(posedge clk_i);
    step <= 1'b1;
    @(posedge clk_i);
    step <= 1'b0;
    lat = 1;
    while (!(up === 1'b1 || dn === 1'b1) && lat < 100) begin
      cyc(1);
      lat++;
    end
    chk("filter lag", 16'(lat >= 32 && lat <= 60), 16'h0001);
    wr(OFS_FILT_CTRL, 16'h0000);
    $display("filter test done");
    wr(OFS_DEC_CTRL, 16'h0101);
    repeat (4) begin
      stp(1'b0, 1);
      chk("src dir", 16'(dir), 16'(pins.phase_b));
    end
    wr(OFS_DEC_CTRL, 16'h0640);
    pdir <= 1'b0;
    cyc(2);
    chk("pin oe", 16'(oen), 16'h0000);
    chk("pin dir", 16'(dpin), 16'(dir));
    pdir <= 1'b1;
    cyc(2);
    chk("pin off", 16'(oen), 16'h0001);
    @(posedge clk_i);
    jolt <= 1'b1;
    @(posedge clk_i);
    jolt <= 1'b0;
    cyc(10);
    chk("err set", 16'(err), 16'h0001);
    wr(OFS_FILT_CTRL, 16'h0100);
    cyc(2);
    chk("err mask", 16'(err), 16'h0000);
    wr(OFS_FILT_CTRL, 16'h0000);
    cyc(2);
    chk("err unmask", 16'(err), 16'h0001);
    wr(OFS_DEC_CTRL, 16'h0600);
    cyc(2);
    chk("err clear", 16'(err), 16'h0000);
    wr(OFS_FILT_CTRL, 16'h0008);
    n_idx = 0;
    @(posedge clk_i);
    idx <= 1'b1;
    @(posedge clk_i);
    idx <= 1'b0;
    cyc(10);
    chk("index spike", 16'(n_idx), 16'h0000);
    @(posedge clk_i);
    idx <= 1'b1;
    cyc(10);
    chk("index accept", 16'(idx_acc), 16'h0001);
    @(posedge clk_i);
    idx <= 1'b0;
    cyc(2);
    $display("pin and error tests done");
    report_and_stop();
  end
endmodule : quadrature_decoder_with_filters_test
